// file: src/rpds_consts.vh
// Timing constants for the reset and power-down sequencer.
// Assumes a 100 MHz mclk; counts are derived from times in ns.
`ifndef RPDS_CONSTS_VH
`define RPDS_CONSTS_VH

`define RPDS_CLK_PERIOD_NS      10
`define RPDS_VALID_LOW_RST_NS   100
`define RPDS_RST_PULSE_MIN_NS   100
`define RPDS_CTRL_READY_NS      3500000
`define RPDS_RUN_MIN_NS         10000000
`define RPDS_PDN_VALID_LOW_NS   725000
`define RPDS_PDN_PULSE_MIN_NS   1000
`define RPDS_POWERUP_HOLD_NS    100000

// Cycle counts; least times round up, longest times round down
`define RPDS_VALID_LOW_RST_CYC  (`RPDS_VALID_LOW_RST_NS / `RPDS_CLK_PERIOD_NS)
`define RPDS_RST_PULSE_CYC     ((`RPDS_RST_PULSE_MIN_NS + `RPDS_CLK_PERIOD_NS - 1) / `RPDS_CLK_PERIOD_NS)
`define RPDS_CTRL_READY_CYC     (`RPDS_CTRL_READY_NS / `RPDS_CLK_PERIOD_NS)
`define RPDS_RUN_CYC           ((`RPDS_RUN_MIN_NS + `RPDS_CLK_PERIOD_NS - 1) / `RPDS_CLK_PERIOD_NS)
`define RPDS_PDN_VALID_LOW_CYC  (`RPDS_PDN_VALID_LOW_NS / `RPDS_CLK_PERIOD_NS)
`define RPDS_PDN_PULSE_CYC     ((`RPDS_PDN_PULSE_MIN_NS + `RPDS_CLK_PERIOD_NS - 1) / `RPDS_CLK_PERIOD_NS)

`endif

// file: src/rpds_sequencer.v
// Reset and power-down sequencer for the power stage of an amplifier.
// Assumes reset and power-down pins are already synchronous to mclk.
`timescale 1ns/1ps
`include "rpds_consts.vh"

// Notes on behaviour
// - Reset input drives power-stage valid low within about 100 ns, except in ST_PDWAIT, where reset is ignored.
// - Device needs at least 10 ms after start command before running.
// - Reset assertion is ignored while the device is powered down.
// - Power-down input drives valid low after about 725 us.
// - Power-down assertion is ignored while the device is held in reset.
module rpds_sequencer #(
	parameter CTRL_READY_CYC = `RPDS_CTRL_READY_CYC,
	parameter RUN_CYC        = `RPDS_RUN_CYC,
	parameter PDN_LOW_CYC    = `RPDS_PDN_VALID_LOW_CYC,
	parameter CNT_W          = 24
) (
	mclk,
	sys_rst,
	reset_n,
	power_down_request_n,
	start_cmd,
	power_stage_valid,
	ctrl_ready,
	running,
	powered_down
);
	input  wire mclk;
	input  wire sys_rst;
	input  wire reset_n;
	input  wire power_down_request_n;
	input  wire start_cmd;
	output reg  power_stage_valid;
	output reg  ctrl_ready;
	output reg  running;
	output reg  powered_down;

	// ========================================================
	// States
	localparam [2:0] ST_RESET = 3'h0;
	localparam [2:0] ST_BOOT  = 3'h1;
	localparam [2:0] ST_IDLE  = 3'h2;
	localparam [2:0] ST_START = 3'h3;
	localparam [2:0] ST_RUN   = 3'h4;
	localparam [2:0] ST_PDWAIT = 3'h5;
	localparam [2:0] ST_PDOWN = 3'h6;

	localparam integer RST_PULSE = `RPDS_RST_PULSE_CYC;
	localparam integer PDN_PULSE = `RPDS_PDN_PULSE_CYC;
	localparam integer N_PIN     = 2;

	reg [2:0]        state_r;
	reg [2:0]        state_nxt;
	reg [CNT_W-1:0]  cnt_r;
	reg [CNT_W-1:0]  cnt_nxt;
	reg              valid_nxt;
	reg              ready_nxt;
	reg              running_nxt;
	reg              pdown_nxt;
	wire [N_PIN-1:0] pin_low;
	wire [N_PIN-1:0] pin_ok;
	wire             rst_ok;
	wire             pdn_ok;

	// ========================================================
	// Pulse-width qualifiers
	// Glitches shorter than the minimum width must not disturb the stage.
	// Channel 0 watches the reset pin, channel 1 the power-down pin.
	assign pin_low[0] = ~reset_n;
	assign pin_low[1] = ~power_down_request_n;

	genvar gi;
	generate
		for (gi = 0; gi < N_PIN; gi = gi + 1) begin : g_qual
			localparam integer MIN_W = (gi == 0) ? RST_PULSE : PDN_PULSE;
			reg [7:0] width_r;
			// Count saturates so a long hold cannot wrap back to zero
			always @(posedge mclk) begin
				if (sys_rst) begin
					width_r <= 8'h00;
				end else if (!pin_low[gi]) begin
					width_r <= 8'h00;
				end else if (width_r < MIN_W) begin
					width_r <= width_r + 8'h01;
				end
			end
			// Accepted on the edge that sees the pin low for MIN_W cycles
			assign pin_ok[gi] = pin_low[gi] && (width_r >= MIN_W - 1);
		end
	endgenerate

	assign rst_ok = pin_ok[0];
	assign pdn_ok = pin_ok[1];

	// ========================================================
	// Sequencer
	always @* begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
		ST_RESET: begin
			cnt_nxt = {CNT_W{1'b0}};
			if (reset_n)
				state_nxt = ST_BOOT;
		end
		ST_BOOT: begin
			cnt_nxt = cnt_r + 1'b1;
			if (rst_ok) begin
				state_nxt = ST_RESET;
			end else if (cnt_r == CTRL_READY_CYC - 1) begin
				state_nxt = ST_IDLE;
				cnt_nxt   = {CNT_W{1'b0}};
			end
		end
		ST_IDLE, ST_START, ST_RUN: begin
			if (rst_ok) begin
				state_nxt = ST_RESET;
			end else if (pdn_ok) begin
				state_nxt = ST_PDWAIT;
				cnt_nxt   = {CNT_W{1'b0}};
			end else if (state_r == ST_IDLE) begin
				if (start_cmd) begin
					state_nxt = ST_START;
					cnt_nxt   = {CNT_W{1'b0}};
				end
			end else if (state_r == ST_START) begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == RUN_CYC - 1)
					state_nxt = ST_RUN;
			end
		end
		ST_PDWAIT: begin
			// Reset is not honoured once power-down is in progress
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == PDN_LOW_CYC - 1)
				state_nxt = ST_PDOWN;
		end
		ST_PDOWN: begin
			if (power_down_request_n) begin
				state_nxt = ST_START;
				cnt_nxt   = {CNT_W{1'b0}};
			end
		end
		default: state_nxt = ST_RESET;
		endcase
	end

	// ========================================================
	// Output decode
	// Outputs follow the next state so each flag lands with its state
	always @* begin
		valid_nxt   = 1'b0;
		ready_nxt   = 1'b0;
		running_nxt = 1'b0;
		pdown_nxt   = 1'b0;
		case (state_nxt)
		ST_RESET: begin
			valid_nxt = 1'b0;
		end
		ST_BOOT: begin
			// Power-down in reset never leaves ST_RESET/ST_BOOT
			valid_nxt = 1'b0;
		end
		ST_IDLE: begin
			ready_nxt = 1'b1;
		end
		ST_START: begin
			ready_nxt = 1'b1;
			valid_nxt = 1'b0;
		end
		ST_RUN: begin
			ready_nxt   = 1'b1;
			running_nxt = 1'b1;
			valid_nxt   = 1'b1;
		end
		ST_PDWAIT: begin
			// Stage keeps switching until the stop delay expires
			ready_nxt = 1'b1;
			valid_nxt = 1'b1;
		end
		ST_PDOWN: begin
			ready_nxt = 1'b1;
			pdown_nxt = 1'b1;
		end
		default: begin
			valid_nxt = 1'b0;
		end
		endcase
	end

	// ========================================================
	// Registers
	// Every output is a flop, so the host never sees decode glitches
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_r           <= ST_RESET;
			cnt_r             <= {CNT_W{1'b0}};
			power_stage_valid <= 1'b0;
			ctrl_ready        <= 1'b0;
			running           <= 1'b0;
			powered_down      <= 1'b0;
		end else begin
			state_r           <= state_nxt;
			cnt_r             <= cnt_nxt;
			power_stage_valid <= valid_nxt;
			ctrl_ready        <= ready_nxt;
			running           <= running_nxt;
			powered_down      <= pdown_nxt;
		end
	end

endmodule // rpds_sequencer

// file: dv/rpds_chk.sv
// Checker for the reset and power-down sequencer ports.
// Assumes shortened counts handed on by the bind below.
`timescale 1ns/1ps
module rpds_chk #(
	parameter CTRL_READY_CYC = 20,
	parameter RUN_CYC        = 30,
	parameter PDN_LOW_CYC    = 25
) (
	input wire mclk, sys_rst, reset_n, power_down_request_n, start_cmd,
	input wire power_stage_valid, ctrl_ready, running, powered_down
);
	localparam int CL = CTRL_READY_CYC - 2;
	localparam int RL = RUN_CYC - 2;
	localparam int PL = PDN_LOW_CYC + 95;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_rst_valid_low: assert property (running && !powered_down ##1
		!reset_n [*8] ##1 !reset_n ##1 !reset_n |-> ##[0:2] !power_stage_valid)
		else $error("valid not low after reset");
	a_ready_delay: assert property ($rose(reset_n) && !ctrl_ready &&
		!powered_down |-> ##CL !ctrl_ready ##[1:4] ctrl_ready)
		else $error("control port ready at wrong time");
	a_run_delay: assert property (start_cmd && ctrl_ready && !running
		|-> ##RL !running ##[1:4] running) else $error("start delay wrong");
	a_pd_wait: assert property ($fell(power_down_request_n) && running
		|-> ##PL power_stage_valid ##[1:12] !power_stage_valid && powered_down)
		else $error("power-down valid timing wrong");
	a_rst_in_pd: assert property (powered_down && !reset_n &&
		!power_down_request_n |=> powered_down) else $error("reset in pd");
	a_pd_in_rst: assert property (!reset_n && !powered_down |=>
		!powered_down) else $error("power-down taken in reset");
	a_valid_run: assert property ($rose(power_stage_valid) |-> running)
		else $error("valid rose before start-up done");
	a_pd_no_valid: assert property (powered_down |-> !power_stage_valid)
		else $error("valid high while powered down");
endmodule // rpds_chk
bind rpds_sequencer rpds_chk #(.CTRL_READY_CYC(CTRL_READY_CYC),
	.RUN_CYC(RUN_CYC), .PDN_LOW_CYC(PDN_LOW_CYC)) u_rpds_chk (
	.mclk(mclk), .sys_rst(sys_rst), .reset_n(reset_n),
	.power_down_request_n(power_down_request_n), .start_cmd(start_cmd),
	.power_stage_valid(power_stage_valid), .ctrl_ready(ctrl_ready),
	.running(running), .powered_down(powered_down));

// file: dv/rpds_host.sv
// Host model driving the reset, power-down and start pins.
// Pins change just after rising edges of mclk.
`timescale 1ns/1ps
module rpds_host (
	input  wire mclk,
	output reg  reset_n,
	output reg  power_down_request_n,
	output reg  start_cmd
);
	initial begin
		reset_n = 1'b0;
		power_down_request_n = 1'b1;
		start_cmd = 1'b0;
	end
	// Supply assumed good at time zero; 10000 cycles is 100 us
	task power_up; begin
		repeat (10000) @(posedge mclk);
		reset_n <= 1'b1;
	end endtask
	task rst_pulse(input integer n); begin
		@(posedge mclk) reset_n <= 1'b0;
		repeat (n) @(posedge mclk);
		reset_n <= 1'b1;
	end endtask
	task pd_pulse(input integer n); begin
		@(posedge mclk) power_down_request_n <= 1'b0;
		repeat (n) @(posedge mclk);
		power_down_request_n <= 1'b1;
	end endtask
	// Called only once ctrl_ready is seen
	task start; begin
		@(posedge mclk) start_cmd <= 1'b1;
		@(posedge mclk) start_cmd <= 1'b0;
	end endtask
endmodule // rpds_host

// file: dv/rpds_sequencer_tb.sv
// Testbench for the sequencer, with the host model at its pins.
// Counts shortened by parameters; 100 MHz mclk.
`timescale 1ns/1ps
module rpds_sequencer_tb;
	reg     mclk = 1'b0;
	reg     sys_rst = 1'b1;
	wire    reset_n, power_down_request_n, start_cmd;
	wire    power_stage_valid, ctrl_ready, running, powered_down;
	wire [2:0] st = {powered_down, running, ctrl_ready};
	integer error_cnt = 0;
	integer total_checks = 0;
	always #5 mclk = ~mclk;
	rpds_sequencer #(.CTRL_READY_CYC(20), .RUN_CYC(30), .PDN_LOW_CYC(25))
		u_rpds_sequencer (.mclk(mclk), .sys_rst(sys_rst),
		.reset_n(reset_n), .power_down_request_n(power_down_request_n),
		.start_cmd(start_cmd), .power_stage_valid(power_stage_valid),
		.ctrl_ready(ctrl_ready), .running(running),
		.powered_down(powered_down));
	rpds_host u_rpds_host (.mclk(mclk), .reset_n(reset_n),
		.power_down_request_n(power_down_request_n),
		.start_cmd(start_cmd));
	task final_report; begin
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	end endtask
	task chk(input string n, input logic e, input logic g); begin
		total_checks = total_checks + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	end endtask
	task wt(input integer b); integer i; begin
		for (i = 0; i < 2000 && st[b] !== 1'b1; i = i + 1) @(posedge mclk) #1;
		if (st[b] !== 1'b1) begin
			error_cnt = error_cnt + 1;
			final_report;
		end
	end endtask
	task t_boot; begin
		fork u_rpds_host.power_up; u_rpds_host.pd_pulse(150); join
		chk("powered_down", 1'b0, powered_down);
		wt(0);
		chk("power_stage_valid", 1'b0, power_stage_valid);
		u_rpds_host.start;
		wt(1);
		chk("power_stage_valid", 1'b1, power_stage_valid);
	end endtask
	task t_rst; begin
		u_rpds_host.rst_pulse(5); #20;
		chk("power_stage_valid", 1'b1, power_stage_valid);
		u_rpds_host.rst_pulse(10); #15;
		chk("power_stage_valid", 1'b0, power_stage_valid);
		wt(0); u_rpds_host.start; wt(1);
	end endtask
	task t_pd; begin
		fork u_rpds_host.pd_pulse(200); begin
			repeat (110) @(posedge mclk); #1;
			chk("power_stage_valid", 1'b1, power_stage_valid);
			wt(2); u_rpds_host.rst_pulse(20); #1;
			chk("powered_down", 1'b1, powered_down);
		end join
		#1;
		chk("power_stage_valid", 1'b0, power_stage_valid);
		wt(1);
		chk("power_stage_valid", 1'b1, power_stage_valid);
	end endtask
	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		t_boot;
		t_rst;
		t_pd;
		final_report;
	end
endmodule // rpds_sequencer_tb
